// ### logic/mpc_control.sv
// Our own choices: the address map and register access over APB.
`default_nettype none
// What this block does
// - Soft disable bit forces mapped pins inactive
// - Pins resume after bit clear and cycle start
// - Soft disable raises no interrupt or flag
// - Manual mode clears faults every clock
// - First enable reloads, sets flag, may interrupt
// - Complementary sensing starts on odd duty registers
// - Reset zeros duty and prescale; modulus kept
// - Modulus never reset; software writes nonzero
// - Prescale zero drives next clock, else wait cycle
// - Disable tristates pins unless manual, clears counter, zeros generator
// - Faults, manual pins, flag survive module disable
// - Wait mode keeps running; reload interrupt wakes
// - Break freezes generator, faults still force inactive
// - Break without clear enable protects flags
// - Counter high read latches low byte
// - Edge period equals modulus, center twice
// - Modulus buffered; reads return buffer
// - Six signed duty values compared against modulus
// - Duty buffered; pairs share one register
// - Load ok reads zero, self clears on load
// - Two-bit select picks correction scheme
// - Dead-time count written once, never shortened
// - Reload flag: read set, write zero clears
// - Reload every 1, 2, 4 or 8 cycles
module mpc_control
    import mpc_pkg::*;
(
    input wire logic sys_clk, // Bus clock, 40 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire mpc_pkg::mpc_apb_req_s apb_req, // APB request group
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [31:0] prdata, // APB read data
    input wire logic [1:0] fault_bank_in, // Filtered fault per bank, pin side
    input wire logic [2:0] current_sense_in, // Current sense pins 1 to 3
    input wire logic break_mode, // Debug break state, same clock
    input wire logic break_clear_enable, // Break flag clearing allowed
    output logic [5:0] pwm_out, // PWM pin levels
    output logic [5:0] pwm_oe_n, // Pin output enable, low drives
    output logic reload_irq // Reload interrupt request
);
    import mpc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Low bits of the divider that must all be set for one tick
    function automatic logic [2:0] pow_mask(input logic [1:0] code);
        case (code)
            2'h0: pow_mask = 3'h0;
            2'h1: pow_mask = 3'h1;
            2'h2: pow_mask = 3'h3;
            default: pow_mask = 3'h7;
        endcase
    endfunction

    // Signed duty against the counter; saturates at both ends
    function automatic logic duty_on(input logic [15:0] duty, input logic [11:0] md,
                                     input logic [11:0] cn);
        if (duty[15] || duty == 16'h0000) begin
            duty_on = 1'b0;
        end else if (duty >= {4'h0, md}) begin
            duty_on = 1'b1;
        end else begin
            duty_on = cn < duty[11:0];
        end
    endfunction

    // Pins hit by the two banks through the mapping register
    function automatic logic [5:0] bank_pins(input logic [1:0] bank, input logic [7:0] map);
        logic [5:0] m;
        m = 6'h00;
        if (bank[0]) begin
            m[3:0] = m[3:0] | map[3:0];
        end
        if (bank[1]) begin
            m[5:2] = m[5:2] | map[7:4];
        end
        bank_pins = m;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mpc_state_s s; // Registered state
    mpc_state_s next_s; // Next state
    logic [7:0] addr; // Request address
    logic access; // First access cycle
    logic wr_done; // Write completes this edge
    logic rd_done; // Read completes this edge
    logic flag_clear; // Clearing sequence finished
    logic freeze_flags; // Break protects flags
    logic en_rise; // Module just enabled
    logic tick; // Prescaled counter step
    logic cyc_start; // New PWM cycle
    logic cyc_mid; // Center turn point
    logic reload; // Reload cycle begins
    logic boundary; // Point where disables may lift
    logic drive; // Pins are driven
    logic [5:0] dmask; // Pins forced inactive
    logic [5:0] raw; // Pin level before disables
    logic [2:0] didx; // Duty register index
    logic [15:0] dsel; // Duty chosen for a pair

    assign addr = apb_req.paddr;
    assign access = apb_req.psel & apb_req.penable & ~s.pready;
    assign wr_done = apb_req.psel & apb_req.penable & s.pready & apb_req.pwrite;
    assign rd_done = apb_req.psel & apb_req.penable & s.pready & ~apb_req.pwrite;
    assign didx = 3'((addr - OFF_DUTY0) >> 2);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        flag_clear = 1'b0;
        freeze_flags = break_mode & ~break_clear_enable;
        tick = 1'b0;
        cyc_start = 1'b0;
        cyc_mid = 1'b0;
        dsel = 16'h0000;
        // Pin side inputs pass two flops first
        next_s.flt1 = fault_bank_in;
        next_s.flt2 = s.flt1;
        next_s.is1 = current_sense_in;
        next_s.is2 = s.is1;

        // APB answer: one wait state, data registered with ready
        next_s.pready = access;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0000_0000;
        if (access) begin
            case (addr)
                OFF_CTRL_ONE: begin // Load ok always reads zero
                    next_s.prdata[7:0] = {s.soft_disable_bank_x, s.soft_disable_bank_y, s.irq_en, s.flag, s.isens, 1'b0, s.en};
                end
                OFF_CTRL_TWO: begin
                    next_s.prdata[8:0] = {s.compl, s.rate, s.center, s.pol, s.presc_buf};
                end
                OFF_MODULUS: next_s.prdata[11:0] = s.mod_buf; // Buffer, not active
                OFF_CNT_HI: next_s.prdata[3:0] = s.cnt[11:8];
                OFF_CNT_LO: next_s.prdata[7:0] = s.lo_held ? s.lo_latch : s.cnt[7:0];
                OFF_DEAD: next_s.prdata[7:0] = s.dead;
                OFF_DISABLE_MAPPING_REG: next_s.prdata[7:0] = s.disable_mapping_reg;
                OFF_MANUAL: next_s.prdata[6:0] = {s.manual_ctl, s.manual_out};
                default: begin
                    if (addr >= OFF_DUTY0 && addr < OFF_DUTY_END && addr[1:0] == 2'h0) begin
                        next_s.prdata[15:0] = s.duty_buf[didx];
                    end else begin
                        next_s.pslverr = 1'b1; // Unmapped
                    end
                end
            endcase
        end

        // Read side effects land on the completing edge
        if (rd_done && addr == OFF_CNT_HI) begin
            next_s.lo_latch = s.cnt[7:0]; // Hold low byte until read
            next_s.lo_held = 1'b1;
        end
        if (rd_done && addr == OFF_CNT_LO) begin
            next_s.lo_held = 1'b0;
        end
        if (rd_done && addr == OFF_CTRL_ONE && s.flag) begin
            next_s.armed = 1'b1; // First half of clear sequence
        end

        // Register writes
        if (wr_done) begin
            case (addr)
                OFF_CTRL_ONE: begin
                    // Disable bits touch no flag or interrupt
                    next_s.soft_disable_bank_x = apb_req.pwdata[C1_SOFT_DISABLE_BANK_X];
                    next_s.soft_disable_bank_y = apb_req.pwdata[C1_SOFT_DISABLE_BANK_Y];
                    next_s.irq_en = apb_req.pwdata[C1_IRQEN];
                    next_s.isens = apb_req.pwdata[C1_ISENS +: 2];
                    next_s.load_ok = apb_req.pwdata[C1_LOAD_OK];
                    next_s.en = apb_req.pwdata[C1_EN];
                    flag_clear = ~apb_req.pwdata[C1_FLAG] & s.armed & ~freeze_flags;
                end
                OFF_CTRL_TWO: begin
                    next_s.presc_buf = apb_req.pwdata[C2_PRSC +: 2];
                    next_s.pol = apb_req.pwdata[C2_POL +: 3];
                    next_s.center = apb_req.pwdata[C2_CENTER];
                    next_s.rate = apb_req.pwdata[C2_RATE +: 2];
                    next_s.compl = apb_req.pwdata[C2_COMPL];
                end
                OFF_MODULUS: next_s.mod_buf = apb_req.pwdata[11:0];
                OFF_DEAD: begin
                    // Locked after first write so dead time cannot shrink
                    if (!s.dead_wr) begin
                        next_s.dead = apb_req.pwdata[7:0];
                        next_s.dead_wr = 1'b1;
                    end
                end
                OFF_DISABLE_MAPPING_REG: begin
                    if (!s.disable_mapping_reg_wr) begin
                        next_s.disable_mapping_reg = apb_req.pwdata[7:0];
                        next_s.disable_mapping_reg_wr = 1'b1;
                    end
                end
                OFF_MANUAL: begin
                    next_s.manual_out = apb_req.pwdata[5:0];
                    next_s.manual_ctl = apb_req.pwdata[MAN_CTL];
                end
                default: begin
                    if (addr >= OFF_DUTY0 && addr < OFF_DUTY_END && addr[1:0] == 2'h0) begin
                        next_s.duty_buf[didx] = apb_req.pwdata[15:0];
                    end
                end
            endcase
        end

        // Counter and prescaler; frozen in break, kept running in wait
        en_rise = next_s.en & ~s.en;
        if (!next_s.en) begin
            next_s.cnt = 12'h000; // Cleared and stopped
            next_s.dir_down = 1'b0;
            next_s.div = 3'h0;
            next_s.rl_cnt = 3'h0;
        end else if (!en_rise && !break_mode) begin
            next_s.div = s.div + DIV_ONE;
            tick = (s.div & pow_mask(s.presc_act)) == pow_mask(s.presc_act);
            if (tick && !s.center) begin
                if (s.cnt >= s.mod_act - CNT_ONE) begin
                    next_s.cnt = 12'h000; // Period of modulus counts
                    cyc_start = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + CNT_ONE;
                end
            end else if (tick && !s.dir_down) begin
                if (s.cnt >= s.mod_act) begin
                    next_s.dir_down = 1'b1; // Turn at modulus, twice the period
                    next_s.cnt = s.cnt - CNT_ONE;
                    cyc_mid = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + CNT_ONE;
                end
            end else if (tick) begin
                if (s.cnt <= CNT_ONE) begin
                    next_s.cnt = 12'h000;
                    next_s.dir_down = 1'b0;
                    cyc_start = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - CNT_ONE;
                end
            end
        end

        // Reload on first enable and every 1, 2, 4 or 8 cycles
        reload = en_rise | (cyc_start & (s.rl_cnt == pow_mask(s.rate)));
        if (cyc_start) begin
            next_s.rl_cnt = reload ? 3'h0 : s.rl_cnt + DIV_ONE;
        end
        if (reload) begin
            next_s.flag = 1'b1; // Set whatever load ok says
            next_s.armed = 1'b0; // A new reload spoils a pending clear
            if (next_s.load_ok) begin
                next_s.mod_act = s.mod_buf;
                next_s.duty_act = next_s.duty_buf;
                next_s.presc_act = next_s.presc_buf;
                next_s.load_ok = 1'b0; // Self clear once loaded
            end
        end else if (flag_clear) begin
            next_s.flag = 1'b0;
            next_s.armed = 1'b0;
        end
        // Without load ok the last loaded modulus stays in use

        // Pair register choice, fixed at cycle start or mid point
        if (en_rise) begin
            next_s.first_cycle = 1'b1;
            next_s.sel = 3'h0; // Odd registers first under sensing
            next_s.hiz_wait = next_s.presc_act != 2'h0;
        end else if (cyc_start) begin
            next_s.first_cycle = 1'b0;
            next_s.hiz_wait = 1'b0; // One full cycle has passed
        end
        if (!en_rise && (cyc_start || cyc_mid)) begin
            case (s.isens)
                CORR_DEAD: next_s.sel = cyc_start ? s.is2 : s.sel;
                CORR_MID: next_s.sel = (cyc_mid || !s.center) ? s.is2 : s.sel;
                default: next_s.sel = cyc_start ? s.pol : s.sel;
            endcase
        end

        // Generator outputs, forced low while disabled
        if (!next_s.en) begin
            next_s.gen_out = 6'h00;
        end else if (!break_mode) begin
            for (int p = 0; p < 3; p++) begin
                if (next_s.compl) begin
                    dsel = next_s.sel[p] ? next_s.duty_act[2 * p + 1] : next_s.duty_act[2 * p];
                    next_s.gen_out[2 * p] = duty_on(dsel, next_s.mod_act, next_s.cnt);
                    next_s.gen_out[2 * p + 1] = ~duty_on(dsel, next_s.mod_act, next_s.cnt);
                end else begin
                    next_s.gen_out[2 * p] = duty_on(next_s.duty_act[2 * p], next_s.mod_act,
                                                   next_s.cnt);
                    next_s.gen_out[2 * p + 1] = duty_on(next_s.duty_act[2 * p + 1],
                                                       next_s.mod_act, next_s.cnt);
                end
            end
        end

        // Disable latches; manual mode has no cycles so it checks each clock
        boundary = (cyc_start & ~en_rise) | next_s.manual_ctl;
        next_s.soft_lat[0] = next_s.soft_disable_bank_x | (s.soft_lat[0] & ~boundary);
        next_s.soft_lat[1] = next_s.soft_disable_bank_y | (s.soft_lat[1] & ~boundary);
        next_s.flt_lat = s.flt2 | (s.flt_lat & ~{2{boundary}}); // Faults work always
        dmask = bank_pins(next_s.soft_lat | next_s.flt_lat, next_s.disable_mapping_reg);

        // Pin stage; manual control drives even when disabled
        drive = next_s.manual_ctl | (next_s.en & ~next_s.hiz_wait);
        if (break_mode) begin
            raw = s.pwm_out; // Output stage frozen; faults still apply
        end else begin
            raw = next_s.manual_ctl ? next_s.manual_out : next_s.gen_out;
        end
        next_s.pwm_out = drive ? (raw & ~dmask) : 6'h00;
        next_s.pwm_oe_n = drive ? 6'h00 : 6'h3f;
        next_s.irq = next_s.flag & next_s.irq_en; // Wakes from wait

        // Reset clears control; modulus is left alone
        if (!rst_n) begin
            next_s = '0;
            next_s.pwm_oe_n = 6'h3f;
            next_s.mod_buf = s.mod_buf;
            next_s.mod_act = s.mod_act;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign prdata = s.prdata;
    assign pwm_out = s.pwm_out;
    assign pwm_oe_n = s.pwm_oe_n;
    assign reload_irq = s.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_soft_dis_force: assert property (s.soft_disable_bank_x && s.disable_mapping_reg[0] |-> !pwm_out[0])
        else $error("bank x disable did not force pin 0 low");
    // A live count off zero means no cycle start came, so the hold must stay
    a_soft_dis_hold: assert property (
        s.soft_lat[0] ##1 (!s.manual_ctl && s.cnt != 12'h000) |-> s.soft_lat[0])
        else $error("bank x disable released mid cycle");
    a_enable_reload: assert property ($rose(s.en) |-> s.flag)
        else $error("enable did not set reload flag");
    a_irq_follow: assert property (s.flag && s.irq_en |-> reload_irq)
        else $error("reload interrupt not raised");
    a_load_ok_read: assert property (pready && addr == OFF_CTRL_ONE && !apb_req.pwrite
        |-> !prdata[C1_LOAD_OK])
        else $error("load ok read as one");
    a_off_tristate: assert property (!s.en && !s.manual_ctl |-> pwm_oe_n == 6'h3f
        && s.cnt == 12'h000 && s.gen_out == 6'h00)
        else $error("disabled module still active");
    a_fast_drive: assert property ($rose(s.en) && s.presc_act == 2'h0 && !s.manual_ctl
        |-> pwm_oe_n == 6'h00)
        else $error("pins not driven after enable");
    a_break_flag: assert property (
        break_mode && !break_clear_enable && s.flag |=> s.flag)
        else $error("flag cleared in protected break");
    a_cnt_bound: assert property (s.en && s.mod_act != 12'h000 && !$rose(s.en)
        && $stable(s.mod_act) |-> s.cnt <= s.mod_act)
        else $error("counter passed modulus");

    c_reload_load: cover property (s.load_ok ##1 !s.load_ok && s.flag);
    c_flag_clear: cover property (s.flag ##[1:50] !s.flag);
    c_fault_force: cover property (s.flt2 != 2'h0 && pwm_oe_n == 6'h00);
endmodule
`default_nettype wire

// ### logic/mpc_pkg.sv
`default_nettype none
package mpc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_ONE = 8'h00; // Control register one
    localparam logic [7:0] OFF_CTRL_TWO = 8'h04; // Rate, correction, prescale, modes
    localparam logic [7:0] OFF_MODULUS = 8'h08; // Buffered modulus
    localparam logic [7:0] OFF_CNT_HI = 8'h0c; // Counter high bits
    localparam logic [7:0] OFF_CNT_LO = 8'h10; // Counter low byte
    localparam logic [7:0] OFF_DEAD = 8'h14; // Dead-time count, write once
    localparam logic [7:0] OFF_DISABLE_MAPPING_REG = 8'h18; // Disable mapping, write once
    localparam logic [7:0] OFF_MANUAL = 8'h1c; // Manual output control
    localparam logic [7:0] OFF_DUTY0 = 8'h20; // First of six duty registers
    localparam logic [7:0] OFF_DUTY_END = 8'h38; // One past the last duty register
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C1_EN = 0; // module_enable
    localparam int C1_LOAD_OK = 1; // load_ok, write only
    localparam int C1_ISENS = 2; // correction_method_sel, 2 bits
    localparam int C1_FLAG = 4; // reload_flag
    localparam int C1_IRQEN = 5; // reload_irq_enable
    localparam int C1_SOFT_DISABLE_BANK_Y = 6; // soft_disable_bank_y
    localparam int C1_SOFT_DISABLE_BANK_X = 7; // soft_disable_bank_x
    localparam int C2_PRSC = 0; // clock_prescale_sel, 2 bits
    localparam int C2_POL = 2; // pair soft correction bits, 3 bits
    localparam int C2_CENTER = 5; // Center-aligned counting
    localparam int C2_RATE = 6; // reload_rate_sel, 2 bits
    localparam int C2_COMPL = 8; // Complementary pairs
    localparam int MAN_CTL = 6; // manual_output_control above six output bits
    // ------------------------------------------------------------
    // Correction schemes
    // ------------------------------------------------------------
    localparam logic [1:0] CORR_SOFT = 2'h0; // Pair bits pick the register
    localparam logic [1:0] CORR_DEAD = 2'h1; // Sense during dead time
    localparam logic [1:0] CORR_MID = 2'h2; // Sense at mid or end of cycle
    localparam logic [11:0] CNT_ONE = 12'h001; // Counter step
    localparam logic [2:0] DIV_ONE = 3'h1; // Prescale divider step
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } mpc_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic en, load_ok, flag, armed, irq_en, soft_disable_bank_x, soft_disable_bank_y;
        logic [1:0] isens, rate, presc_buf, presc_act;
        logic [2:0] pol, sel, div, rl_cnt;
        logic center, compl, dir_down, hiz_wait, first_cycle, lo_held;
        logic [11:0] mod_buf, mod_act, cnt;
        logic [5:0][15:0] duty_buf;
        logic [5:0][15:0] duty_act;
        logic [7:0] lo_latch, dead, disable_mapping_reg;
        logic dead_wr, disable_mapping_reg_wr, manual_ctl;
        logic [5:0] manual_out, gen_out, pwm_out, pwm_oe_n;
        logic [1:0] soft_lat, flt_lat, flt1, flt2;
        logic [2:0] is1, is2;
        logic irq;
    } mpc_state_s;
endpackage
`default_nettype wire

// ### tb/mpc_stage_model.sv
`default_nettype none
// ------------------------------------------------------------
// Power stage seen from the gate pins
// ------------------------------------------------------------
module mpc_stage_model (
    input wire logic sys_clk, // Bus clock
    input wire logic [5:0] pwm_out, // Gate levels
    input wire logic [5:0] pwm_oe_n, // Low where driven
    input wire logic trip, // Bench commands an overcurrent
    output logic [1:0] fault_bank_in = 2'h0, // Bank X in bit 0
    output logic [2:0] current_sense_in = 3'h0 // Phase current sign
);
    timeunit 1ns;
    timeprecision 1ps;
    // Comparator output settles on the clock; only bank X trips
    always @(posedge sys_clk) begin
        fault_bank_in <= {1'b0, trip};
        // A released top gate reads as pulled low, not last level
        current_sense_in <= {pwm_out[4], pwm_out[2], pwm_out[0]}
            & ~{pwm_oe_n[4], pwm_oe_n[2], pwm_oe_n[0]};
    end
endmodule
`default_nettype wire

// ### tb/test_motor_pwm_control_logic.sv
`default_nettype none
module test_motor_pwm_control_logic;
    import mpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bench signals and table
    // ------------------------------------------------------------
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} mpc_row_s;
    logic sys_clk = 1'b0; // 25 ns period
    logic rst_n = 1'b0; // Held low 8 cycles
    mpc_apb_req_s req = '0; // APB master request
    logic trip = 1'b0; // Fault command to stage
    logic brk = 1'b0; // Debug break state
    logic bce = 1'b0; // Break flag clearing allowed
    logic pready, pslverr, reload_irq, err;
    logic [31:0] prdata, rd;
    logic [5:0] pwm_out, pwm_oe_n;
    logic [1:0] fault;
    logic [2:0] sense;
    int errors = 0;
    int tests_run = 0;
    // Slow reload rate keeps the flag quiet while clearing it
    mpc_row_s rows [4] = '{'{OFF_CTRL_TWO, 32'h0c0, 32'h0c0, 1'b0},
        '{OFF_MODULUS, 32'h100, 32'h100, 1'b0}, '{OFF_DISABLE_MAPPING_REG, 32'h0f, 32'h0f, 1'b0},
        '{OFF_DUTY_END, 32'h5a, 32'h0, 1'b1}};
    always #12.5 sys_clk = ~sys_clk;
    mpc_control mpc_control_inst (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .fault_bank_in(fault),
        .current_sense_in(sense), .break_mode(brk), .break_clear_enable(bce),
        .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .reload_irq(reload_irq));
    mpc_stage_model mpc_stage_model_inst (.sys_clk(sys_clk), .pwm_out(pwm_out),
        .pwm_oe_n(pwm_oe_n), .trip(trip), .fault_bank_in(fault), .current_sense_in(sense));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One transfer; ready and data are taken at the rising edge the slave sees
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
        int n = 0;
        @(posedge sys_clk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= w;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask
    // Bounded wait for a pin pattern; the caller compares afterwards
    task automatic wait_out(input logic [5:0] exp, input int n);
        int k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (pwm_out !== exp && k < n);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(pwm_oe_n, 32'h3f, "oe after reset");
        chk({pwm_out, reload_irq}, 32'h0, "pins after reset");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].r, "row read");
            chk(err, rows[i].e, "row error");
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFF_DUTY0 + 8'(4 * i), 32'h7fff);
            apb(1'b0, OFF_DUTY0 + 8'(4 * i), 32'h0);
            chk(rd, 32'h7fff, "duty read");
        end
        apb(1'b1, OFF_CTRL_ONE, 32'h23);
        @(negedge sys_clk);
        chk(pwm_oe_n, 32'h0, "oe on enable");
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk(rd, 32'h31, "control one");
        chk(reload_irq, 32'h1, "irq on enable");
        wait_out(6'h3f, 600);
        chk(pwm_out, 32'h3f, "full duty");
        apb(1'b1, OFF_CTRL_ONE, 32'hb1);
        wait_out(6'h30, 3);
        chk(pwm_out, 32'h30, "bank x off");
        chk(reload_irq, 32'h1, "irq untouched");
        apb(1'b1, OFF_CTRL_ONE, 32'h31);
        @(negedge sys_clk);
        chk(pwm_out, 32'h30, "held to cycle");
        wait_out(6'h3f, 600);
        chk(pwm_out, 32'h3f, "resumed");
        apb(1'b1, OFF_CTRL_ONE, 32'h30);
        @(negedge sys_clk);
        chk(pwm_oe_n, 32'h3f, "oe on disable");
        apb(1'b0, OFF_CNT_HI, 32'h0);
        chk(rd, 32'h0, "count high");
        apb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd, 32'h0, "count low");
        chk(reload_irq, 32'h1, "irq kept");
        apb(1'b1, OFF_MANUAL, 32'h7f);
        wait_out(6'h3f, 3);
        chk(pwm_out, 32'h3f, "manual pins");
        @(posedge sys_clk);
        trip <= 1'b1;
        wait_out(6'h30, 8);
        chk(pwm_out, 32'h30, "fault while off");
        @(posedge sys_clk);
        trip <= 1'b0;
        wait_out(6'h3f, 8);
        chk(pwm_out, 32'h3f, "manual fault clear");
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk(rd, 32'h30, "flag read");
        apb(1'b1, OFF_CTRL_ONE, 32'h20);
        repeat (2) @(negedge sys_clk);
        chk(reload_irq, 32'h0, "flag cleared");
        apb(1'b1, OFF_CTRL_ONE, 32'h21);
        @(posedge sys_clk);
        brk <= 1'b1;
        apb(1'b0, OFF_CTRL_ONE, 32'h0);
        chk(rd, 32'h31, "re-enable reload");
        apb(1'b1, OFF_CTRL_ONE, 32'h21);
        @(negedge sys_clk);
        chk(reload_irq, 32'h1, "flag kept in break");
        @(posedge sys_clk);
        trip <= 1'b1;
        wait_out(6'h30, 8);
        chk(pwm_out, 32'h30, "fault in break");
        @(posedge sys_clk);
        trip <= 1'b0;
        brk <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(pwm_oe_n, 32'h3f, "oe after second reset");
        apb(1'b0, OFF_MODULUS, 32'h0);
        chk(rd, 32'h100, "modulus kept");
        stop_test();
    end
endmodule
`default_nettype wire
